/* bench/fct_host_model.sv */
// Host model that programs the timer registers over the plain register port
`timescale 1ns/1ns
module fct_host_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  import fct_pkg::*;
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd
  // Stop first and clear flag and enable, so no stray irq while settings change
  task automatic start(input logic [7:0] preset, input logic [1:0] sel, input logic [7:0] ctrl);
    wr(ADDR_CFG, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_VALUE, preset);
    wr(ADDR_CTRL, ctrl);
    wr(ADDR_CFG, {6'h20, sel});
  endtask : start
endmodule : fct_host_model

/* bench/tb.sv */
// Self-checking testbench for the fixed-cycle timer
`timescale 1ns/1ns
module tb;
  import fct_pkg::*;
  logic clk;
  logic nrst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic irqPinO;
  logic irqPinOe;
  logic [7:0] d;
  logic [7:0] d2;
  int n;
  int w;
  int n_fail = 0;
  int total_checks = 0;
  // Pull-up on the shared irq line
  wire irqN = irqPinOe ? irqPinO : 1'b1;
  fct_timer #(.RTN_MID_CYCLES(300), .RTN_LONG_CYCLES(600)) fct_timer_inst (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .irqPinO(irqPinO), .irqPinOe(irqPinOe));
  fct_host_model fct_host_model_inst (
    .clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_oe(input logic lvl, input int lim, output int c);
    c = 0;
    while (irqPinOe !== lvl && c < lim) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : wait_oe
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic t_regs();
    fct_host_model_inst.rd(ADDR_CTRL, d);
    check(d, 8'h00);
    fct_host_model_inst.rd(ADDR_CFG, d);
    check(d, 8'h00);
    fct_host_model_inst.rd(8'h05, d);
    check(d, 8'h00);
    fct_host_model_inst.wr(ADDR_CTRL, 8'hff);
    fct_host_model_inst.rd(ADDR_CTRL, d);
    check(d, 8'h11);
    fct_host_model_inst.wr(ADDR_VALUE, 8'h5a);
    fct_host_model_inst.wr(ADDR_CFG, 8'h83);
    fct_host_model_inst.rd(ADDR_CFG, d);
    check(d, 8'h83);
    fct_host_model_inst.rd(ADDR_VALUE, d);
    check(d, 8'h5a);
  endtask : t_regs
  task automatic t_level();
    fct_host_model_inst.start(8'h02, 2'b00, 8'h01);
    wait_oe(1'b1, 6000, n);
    check(n >= 2440 && n <= 4890, 1'b1);
    check(irqN, 1'b0);
    fct_host_model_inst.rd(ADDR_CTRL, d);
    check(d, 8'h05);
    fct_host_model_inst.rd(ADDR_VALUE, d);
    fct_host_model_inst.rd(ADDR_VALUE, d2);
    check(d, d2);
    check(d, 8'h02);
    repeat (100) @(posedge clk);
    #1;
    check(irqPinOe, 1'b1);
    fct_host_model_inst.wr(ADDR_CFG, 8'h00);
    fct_host_model_inst.rd(ADDR_CTRL, d);
    check(d, 8'h05);
    fct_host_model_inst.wr(ADDR_CTRL, 8'h01);
    @(posedge clk);
    #1;
    check(irqPinOe, 1'b0);
    // Restart without a fresh preset must stay silent
    fct_host_model_inst.wr(ADDR_CFG, 8'h80);
    wait_oe(1'b1, 6000, n);
    check(irqPinOe, 1'b0);
    fct_host_model_inst.rd(ADDR_CTRL, d);
    check(d, 8'h01);
  endtask : t_level
  task automatic t_repeat();
    fct_host_model_inst.start(8'h01, 2'b00, 8'h11);
    wait_oe(1'b1, 3000, n);
    wait_oe(1'b0, 3000, w);
    check(w, 1220);
    wait_oe(1'b1, 3000, n);
    check(n >= 1221 && n <= 1222, 1'b1);
    wait_oe(1'b0, 3000, w);
    check(w, 1220);
    fct_host_model_inst.start(8'h03, 2'b00, 8'h11);
    wait_oe(1'b1, 8000, n);
    wait_oe(1'b0, 3000, w);
    check(w, 2440);
    wait_oe(1'b1, 8000, n);
    fct_host_model_inst.wr(ADDR_CFG, 8'h00);
    wait_oe(1'b0, 4, n);
    check(irqPinOe, 1'b0);
    fct_host_model_inst.rd(ADDR_CTRL, d);
    check(d, 8'h15);
  endtask : t_repeat
  task automatic t_enable();
    fct_host_model_inst.start(8'h01, 2'b00, 8'h00);
    wait_oe(1'b1, 3000, n);
    check(irqPinOe, 1'b0);
    fct_host_model_inst.rd(ADDR_CTRL, d);
    check(d, 8'h04);
    fct_host_model_inst.wr(ADDR_CTRL, 8'h05);
    wait_oe(1'b1, 4, n);
    check(irqPinOe, 1'b1);
    fct_host_model_inst.wr(ADDR_CTRL, 8'h04);
    wait_oe(1'b0, 4, n);
    check(irqPinOe, 1'b0);
  endtask : t_enable
  // Slower sources must not tick within a span that holds two fast ticks
  task automatic t_sel();
    for (int s = 1; s < 4; s++) begin
      fct_host_model_inst.start(8'h05, s[1:0], 8'h00);
      repeat (5000) @(posedge clk);
      fct_host_model_inst.rd(ADDR_VALUE, d);
      check(d, 8'h05);
    end
  endtask : t_sel
  initial begin
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_level();
    t_repeat();
    t_enable();
    t_sel();
    print_verdict();
  end
  initial begin
    #9000000;
    n_fail++;
    print_verdict();
  end
endmodule : tb

/* hdl/fct_link_if.sv */
// Source ticks and release-timer handshake between the timer core and its helpers
`timescale 1ns/1ns
interface fct_link_if;
  import fct_pkg::*;
  logic tick4096;
  logic tick64;
  logic tickSec;
  logic tickMin;
  logic relStart;
  logic relStop;
  logic [RTN_W-1:0] relLen;
  logic relActive;
  modport ticks(output tick4096, output tick64, output tickSec, output tickMin);
  modport rel(input relStart, input relStop, input relLen, output relActive);
  modport core(input tick4096, input tick64, input tickSec, input tickMin,
               output relStart, output relStop, output relLen, input relActive);
endinterface : fct_link_if

/* hdl/fct_pkg.sv */
// Constants and types shared by the fixed-cycle timer block
// Behaviour
// - Repeated mode pulses irq for release interval
// - Mode bit selects level or repeated irq
// - Run bit rising starts, falling stops timer
// - Running counter decrements once per source tick
// - Select bits pick 4096Hz, 64Hz, second, minute
// - Count stepping 01h to 00h sets flag
// - Event with irq enabled drives irq low
// - Counter reloads preset after each event
// - Counting continues while running, flag regardless
// - Stopping never clears the event flag
// - Stop invalidates count and preset until rewritten
// - Release interval depends on source and preset
// - Second ticks align to seconds update
// - Minute ticks align to minutes update
// - Count reads live, unlatched; host reads twice
// - Level mode holds irq until flag cleared
// - Writing 0 clears flag, 1 ignored
// - Irq enable low blocks and releases irq
package fct_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_CFG = 8'h0e;
  localparam logic [7:0] ADDR_VALUE = 8'h0f;
  localparam int CTRL_MODE_BIT = 4;
  localparam int CTRL_FLAG_BIT = 2;
  localparam int CTRL_IE_BIT = 0;
  localparam int CFG_RUN_BIT = 7;
  localparam int CFG_SEL_LSB = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] COUNT_LAST = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam int CLK_HZ = 10000000;
  localparam int CLK_NS = 100;
  localparam int TICK_HZ = 4096;
  localparam int ACC_W = 25;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  localparam logic [5:0] DIVSEC_LAST = 6'h3f;
  localparam logic [5:0] DIVMIN_LAST = 6'h3b;
  localparam int RTN_SHORT_NS = 122000;
  localparam int RTN_FAST_NS = 244000;
  localparam int RTN_MID_NS = 7813000;
  localparam int RTN_LONG_NS = 15625000;
  localparam int RTN_SHORT_CYC = RTN_SHORT_NS / CLK_NS;
  localparam int RTN_FAST_CYC = RTN_FAST_NS / CLK_NS;
  localparam int RTN_MID_CYC = RTN_MID_NS / CLK_NS;
  localparam int RTN_LONG_CYC = RTN_LONG_NS / CLK_NS;
  localparam int RTN_W = 18;
  typedef enum logic [1:0] {SEL_4096, SEL_64, SEL_SEC, SEL_MIN} fct_sel_e;
endpackage : fct_pkg

/* hdl/fct_release_timer.sv */
// Auto-release interval timer for repeated irq mode
`timescale 1ns/1ns
module fct_release_timer (
  input wire logic clk,
  input wire logic nrst,
  fct_link_if.rel link
);
  import fct_pkg::*;

  typedef struct packed {
    logic active;
    logic [RTN_W-1:0] cnt;
  } fct_rel_s;

  fct_rel_s s_q;
  fct_rel_s s_d;

  always_comb begin
    s_d = s_q;
    if (link.relStop) begin
      s_d.active = 1'b0;
    end else if (link.relStart) begin
      // A new event restarts the interval even if the last one is still running
      s_d.active = 1'b1;
      s_d.cnt = link.relLen - RTN_W'(1);
    end else if (s_q.active) begin
      if (s_q.cnt == '0) begin
        s_d.active = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - RTN_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.relActive = s_q.active;

  a_rel_load: assert property (@(posedge clk) disable iff (!nrst)
    link.relStart && !link.relStop |=> s_q.active && s_q.cnt == $past(link.relLen) - RTN_W'(1))
    else $error("release interval not loaded");
  a_rel_end: assert property (@(posedge clk) disable iff (!nrst)
    s_q.active && s_q.cnt == '0 && !link.relStart |=> !s_q.active)
    else $error("release interval overran");
endmodule : fct_release_timer

/* hdl/fct_tick_gen.sv */
// Source tick divider: 4096 Hz, 64 Hz, seconds and minutes update pulses
`timescale 1ns/1ns
module fct_tick_gen (
  input wire logic clk,
  input wire logic nrst,
  fct_link_if.ticks link
);
  import fct_pkg::*;

  typedef struct packed {
    logic [ACC_W-2:0] acc;
    logic [5:0] div64;
    logic [5:0] divSec;
    logic [5:0] divMin;
    logic t4096;
    logic t64;
    logic tSec;
    logic tMin;
  } fct_tick_s;

  fct_tick_s s_q;
  fct_tick_s s_d;

  // Phase accumulator gives an exact 4096 Hz average from the 10 MHz clock
  always_comb begin
    logic [ACC_W-1:0] sum;
    sum = {1'b0, s_q.acc} + ACC_W'(TICK_HZ);
    s_d = s_q;
    s_d.t4096 = 1'b0;
    s_d.t64 = 1'b0;
    s_d.tSec = 1'b0;
    s_d.tMin = 1'b0;
    if (sum >= ACC_W'(CLK_HZ)) begin
      s_d.acc = (ACC_W-1)'(sum - ACC_W'(CLK_HZ));
      s_d.t4096 = 1'b1;
      s_d.div64 = (s_q.div64 == DIV64_LAST) ? 6'h00 : s_q.div64 + 6'h01;
      if (s_q.div64 == DIV64_LAST) begin
        s_d.t64 = 1'b1;
        // Free-running calendar cadence, so the first period after a start is short
        s_d.divSec = (s_q.divSec == DIVSEC_LAST) ? 6'h00 : s_q.divSec + 6'h01;
        if (s_q.divSec == DIVSEC_LAST) begin
          s_d.tSec = 1'b1;
          s_d.divMin = (s_q.divMin == DIVMIN_LAST) ? 6'h00 : s_q.divMin + 6'h01;
          s_d.tMin = (s_q.divMin == DIVMIN_LAST);
        end
      end
    end else begin
      s_d.acc = (ACC_W-1)'(sum);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.tick4096 = s_q.t4096;
  assign link.tick64 = s_q.t64;
  assign link.tickSec = s_q.tSec;
  assign link.tickMin = s_q.tMin;

  a_tick_nest: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.tMin |-> s_q.tSec) and (s_q.tSec |-> s_q.t64) and (s_q.t64 |-> s_q.t4096))
    else $error("slow tick not aligned to faster tick");
  a_tick_spacing: assert property (@(posedge clk) disable iff (!nrst)
    s_q.t4096 |=> !s_q.t4096 [*8])
    else $error("4096 Hz ticks too close");
endmodule : fct_tick_gen

/* hdl/fct_timer.sv */
// Fixed-cycle countdown timer with level or repeated open-drain interrupt
`timescale 1ns/1ns
module fct_timer #(
  parameter int RTN_MID_CYCLES = fct_pkg::RTN_MID_CYC,
  parameter int RTN_LONG_CYCLES = fct_pkg::RTN_LONG_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic irqPinO,
  output logic irqPinOe
);
  import fct_pkg::*;

  typedef struct packed {
    logic modeRepeat;
    logic irqEnable;
    logic eventFlag;
    logic run;
    fct_sel_e sel;
    logic [7:0] preset;
    logic [7:0] count;
    logic valid;
    logic [7:0] rdData;
    logic irqOe;
  } fct_core_s;

  fct_core_s s_q;
  fct_core_s s_d;
  fct_link_if link();

  logic wrCtrl;
  logic wrCfg;
  logic wrValue;
  logic tickSel;
  logic timerEvent;
  logic [RTN_W-1:0] oeLen;

  fct_tick_gen u_ticks (
    .clk(clk),
    .nrst(nrst),
    .link(link)
  );

  fct_release_timer u_release (
    .clk(clk),
    .nrst(nrst),
    .link(link)
  );

  assign wrCtrl = regWrEn && regAddr == ADDR_CTRL;
  assign wrCfg = regWrEn && regAddr == ADDR_CFG;
  assign wrValue = regWrEn && regAddr == ADDR_VALUE;

  always_comb begin
    case (s_q.sel)
      SEL_4096: tickSel = link.tick4096;
      SEL_64: tickSel = link.tick64;
      SEL_SEC: tickSel = link.tickSec;
      SEL_MIN: tickSel = link.tickMin;
      default: tickSel = 1'b0;
    endcase
  end

  // A stale count after a stop never fires; the preset must be rewritten first
  assign timerEvent = s_q.run && s_q.valid && tickSel && s_q.count == COUNT_LAST;

  // Release interval follows the source and whether the preset is one
  always_comb begin
    case (s_q.sel)
      SEL_4096: link.relLen = (s_q.preset == COUNT_LAST) ? RTN_W'(RTN_SHORT_CYC)
                                                         : RTN_W'(RTN_FAST_CYC);
      SEL_64: link.relLen = (s_q.preset == COUNT_LAST) ? RTN_W'(RTN_MID_CYCLES)
                                                       : RTN_W'(RTN_LONG_CYCLES);
      default: link.relLen = RTN_W'(RTN_LONG_CYCLES);
    endcase
  end

  assign link.relStart = timerEvent && s_q.modeRepeat;
  // Repeated pulses end with the timer or a switch back to level mode
  assign link.relStop = !s_q.run || !s_q.modeRepeat;

  always_comb begin
    s_d = s_q;
    s_d.rdData = BYTE_RESET;
    if (wrCtrl) begin
      s_d.modeRepeat = regWrData[CTRL_MODE_BIT];
      s_d.irqEnable = regWrData[CTRL_IE_BIT];
      if (!regWrData[CTRL_FLAG_BIT]) begin
        s_d.eventFlag = 1'b0;
      end
    end
    // Set wins over a clearing write in the same cycle
    if (timerEvent) begin
      s_d.eventFlag = 1'b1;
    end
    if (wrCfg) begin
      s_d.run = regWrData[CFG_RUN_BIT];
      s_d.sel = fct_sel_e'(regWrData[CFG_SEL_LSB +: 2]);
      if (s_q.run && !regWrData[CFG_RUN_BIT]) begin
        s_d.valid = 1'b0;
      end
    end
    if (wrValue) begin
      // Loading while stopped arms the next start; the host is expected to do so
      s_d.preset = regWrData;
      s_d.count = regWrData;
      if (!s_q.run) begin
        s_d.valid = 1'b1;
      end
    end else if (s_q.run && s_q.valid && tickSel) begin
      // Keeps cycling whatever the flag and irq state are
      if (s_q.count == COUNT_LAST) begin
        s_d.count = s_q.preset;
      end else if (s_q.count != COUNT_ZERO) begin
        s_d.count = s_q.count - 8'h01;
      end
    end
    if (regRdEn) begin
      case (regAddr)
        ADDR_CTRL: begin
          s_d.rdData[CTRL_MODE_BIT] = s_q.modeRepeat;
          s_d.rdData[CTRL_FLAG_BIT] = s_q.eventFlag;
          s_d.rdData[CTRL_IE_BIT] = s_q.irqEnable;
        end
        ADDR_CFG: begin
          s_d.rdData[CFG_RUN_BIT] = s_q.run;
          s_d.rdData[CFG_SEL_LSB +: 2] = s_q.sel;
        end
        // Live count, not latched: it may step between two reads
        ADDR_VALUE: s_d.rdData = s_q.count;
        default: s_d.rdData = BYTE_RESET;
      endcase
    end
    // Level mode follows the flag, repeated mode the release timer
    s_d.irqOe = s_q.irqEnable && (s_q.modeRepeat ? link.relActive : s_q.eventFlag);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  // Open drain: only ever pulls low, released otherwise
  assign irqPinO = 1'b0;
  assign irqPinOe = s_q.irqOe;

  // Counts the cycles of one low pulse; release intervals exceed what a delay range can span
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oeLen <= '0;
    end else if (irqPinOe) begin
      oeLen <= oeLen + RTN_W'(1);
    end else begin
      oeLen <= '0;
    end
  end

  a_event_flag: assert property (@(posedge clk) disable iff (!nrst)
    timerEvent |=> s_q.eventFlag)
    else $error("event did not set the flag");
  a_count_reload: assert property (@(posedge clk) disable iff (!nrst)
    timerEvent && !wrValue |=> s_q.count == $past(s_q.preset))
    else $error("counter did not reload preset");
  a_count_step: assert property (@(posedge clk) disable iff (!nrst)
    s_q.run && s_q.valid && tickSel && !wrValue && s_q.count > COUNT_LAST
    |=> s_q.count == $past(s_q.count) - 8'h01)
    else $error("counter did not step by one");
  a_count_hold: assert property (@(posedge clk) disable iff (!nrst)
    !(s_q.run && tickSel) && !wrValue |=> $stable(s_q.count))
    else $error("counter moved without a tick");
  a_run_start: assert property (@(posedge clk) disable iff (!nrst)
    wrCfg && regWrData[CFG_RUN_BIT] |=> s_q.run)
    else $error("run bit not taken");
  a_stop_flag: assert property (@(posedge clk) disable iff (!nrst)
    s_q.eventFlag && !(wrCtrl && !regWrData[CTRL_FLAG_BIT]) |=> s_q.eventFlag)
    else $error("flag lost without a clearing write");
  a_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
    wrCtrl && !regWrData[CTRL_FLAG_BIT] && !timerEvent |=> !s_q.eventFlag)
    else $error("writing zero did not clear the flag");
  a_flag_write1: assert property (@(posedge clk) disable iff (!nrst)
    !s_q.eventFlag && !timerEvent |=> !s_q.eventFlag)
    else $error("flag set without an event");
  a_level_hold: assert property (@(posedge clk) disable iff (!nrst)
    (!s_q.modeRepeat && s_q.irqEnable && s_q.eventFlag) [*2] |-> irqPinOe)
    else $error("level irq not held");
  a_ie_release: assert property (@(posedge clk) disable iff (!nrst)
    !s_q.irqEnable |=> !irqPinOe)
    else $error("irq driven while disabled");
  a_event_irq: assert property (@(posedge clk) disable iff (!nrst)
    timerEvent && s_q.irqEnable && !wrCtrl ##1 !wrCtrl |=> irqPinOe)
    else $error("event with irq enabled did not pull low");
  a_stop_invalid: assert property (@(posedge clk) disable iff (!nrst)
    wrCfg && s_q.run && !regWrData[CFG_RUN_BIT] |=> !s_q.valid && !timerEvent)
    else $error("stop did not invalidate the count");
  a_repeat_short: assert property (@(posedge clk) disable iff (!nrst)
    irqPinOe && s_q.modeRepeat && s_q.sel == SEL_4096 && s_q.preset == COUNT_LAST
    |-> oeLen < RTN_W'(RTN_SHORT_CYC))
    else $error("short release interval wrong");
  a_repeat_fast: assert property (@(posedge clk) disable iff (!nrst)
    irqPinOe && s_q.modeRepeat && s_q.sel == SEL_4096 && s_q.preset != COUNT_LAST
    |-> oeLen < RTN_W'(RTN_FAST_CYC))
    else $error("repeated irq did not release");
endmodule : fct_timer
